// ==== core/lca_pkg.sv ====
// Package for the line-unit control and alarm block.
// Assumes a single 100 MHz system clock; line-side clocks arrive as pins.
package lca_pkg;
    localparam int CLK_MHZ = 100;
    localparam int NUM_CHAN = 3;
    // Missing-pulse window in transmit clock periods, nominal and tolerance
    localparam int DRIVE_FAULT_TXCLK = 128;
    localparam int DRIVE_FAULT_TOL = 32;
    // Lock compare window in reference clock periods
    localparam int LOCK_WINDOW = 1000;
    // 0.5% of the window, in recovered clock periods
    localparam int LOCK_TOL = LOCK_WINDOW * 5 / 1000;

    // Register offsets (byte addresses)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_LOS = 4'h8;
    // Control register field positions, one bit per channel per field
    localparam int CTRL_AOS_POS = 0;
    localparam int CTRL_LLB_POS = 4;
    localparam int CTRL_RLB_POS = 8;
    localparam int CTRL_MUTE_POS = 12;
    localparam int CTRL_E3_POS = 16;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Status register field positions
    localparam int STAT_DMO_POS = 0;
    localparam int STAT_LOS_POS = 4;
    localparam int STAT_LOL_POS = 8;
    localparam int STAT_HOST_POS = 12;

    typedef enum logic [1:0] {
        LB_NONE,
        LB_ANALOG_LOCAL,
        LB_DIGITAL_LOCAL,
        LB_REMOTE
    } lca_loopback_e;

    typedef struct packed {
        logic allOnes;
        logic localLb;
        logic remoteLb;
        logic muteEn;
    } lca_chan_cfg_s;
endpackage

// ==== core/lca_control_alarm.sv ====
// Control and alarm logic for three line channels.
// Assumes line clocks and pins are asynchronous; clocks and strap pins are synchronised here, data and alarm inputs are only registered once.
// Overview of operation
// - No monitor pulse 128 txclk sets fault
// - Fault holds until a monitor pulse
// - All-ones select sends continuous marks
// - One all-ones mark per transmit clock
// - Host mode ignores all-ones pin
// - LOS indicator follows declared loss, mode-specific
// - Lock loss when clocks differ over 0.5%
// - Each violation pulses indicator, else low
// - In-circuit test low floats all outputs
// - Threshold pin picks one of two thresholds
// - Threshold used only in DS3/STS-1 rate
// - Local high, remote low: analog local loop
// - Both high: digital local loop
// - Remote only: remote loop; none: none
// - Host mode ignores loopback and mute pins
// - Mute enabled forces recovered data low on loss
// - Mute disabled passes recovered data
// - Select pin high means host mode
//
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
module lca_control_alarm #(
    parameter int NCH = lca_pkg::NUM_CHAN
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    // Avalon-MM slave
    input  wire logic [3:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    // Pins
    input  wire logic                host_or_strap_sel,
    input  wire logic                incircuit_test_n,
    input  wire logic                mute_on_loss_enable,
    input  wire logic [NCH-1:0]      monitor_tip_in,
    input  wire logic [NCH-1:0]      monitor_ring_in,
    input  wire logic [NCH-1:0]      tx_all_ones_sel,
    input  wire logic [NCH-1:0]      local_loopback_in,
    input  wire logic [NCH-1:0]      remote_loopback_in,
    input  wire logic [NCH-1:0]      signal_loss_threshold_sel,
    input  wire logic [NCH-1:0]      e3_mode_in,
    input  wire logic [NCH-1:0]      tx_clock_in,
    input  wire logic [NCH-1:0]      reference_clock_in,
    input  wire logic [NCH-1:0]      rx_recovered_clock_in,
    input  wire logic [NCH-1:0]      tx_data_pos_in,
    input  wire logic [NCH-1:0]      tx_data_neg_in,
    input  wire logic [NCH-1:0]      rx_dec_pos_in,
    input  wire logic [NCH-1:0]      rx_dec_neg_in,
    input  wire logic [NCH-1:0]      rx_code_viol_in,
    input  wire logic [NCH-1:0]      rx_loss_hi_thr_in,
    input  wire logic [NCH-1:0]      rx_loss_lo_thr_in,
    // Outputs, all sharing one output enable
    output logic      [NCH-1:0]      drive_fault_out,
    output logic      [NCH-1:0]      rx_signal_loss_out,
    output logic      [NCH-1:0]      rx_lock_loss_out,
    output logic      [NCH-1:0]      code_violation_out,
    output logic      [NCH-1:0]      rx_data_pos,
    output logic      [NCH-1:0]      rx_data_neg,
    output logic      [NCH-1:0]      tx_line_tip,
    output logic      [NCH-1:0]      tx_line_ring,
    output lca_pkg::lca_loopback_e [NCH-1:0] loopbackMode,
    output logic                     outputsEnable
);
    localparam int SW = 10 * NCH + 3;
    localparam int LW = $clog2(lca_pkg::LOCK_WINDOW + 1);
    localparam int CW = $clog2(2 * lca_pkg::LOCK_WINDOW + 1);
    localparam int FW = 8;
    localparam logic [FW-1:0] FAULT_CNT =
        FW'(lca_pkg::DRIVE_FAULT_TXCLK);
    localparam logic [LW-1:0] WIN_END = LW'(lca_pkg::LOCK_WINDOW);
    localparam logic [CW-1:0] CNT_LO =
        CW'(lca_pkg::LOCK_WINDOW - lca_pkg::LOCK_TOL);
    localparam logic [CW-1:0] CNT_HI =
        CW'(lca_pkg::LOCK_WINDOW + lca_pkg::LOCK_TOL);

    // Status fields are four bits wide per alarm
    if (NCH < 1 || NCH > 4) begin : gBadNch
        $error("NCH must lie between 1 and 4");
    end

    function automatic logic riseOf(input logic [2:0] s);
        return s[1] & ~s[2];
    endfunction

    // Reset release
    logic [1:0] rstSync;
    logic       rstN;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            rstSync <= 2'h0;
        else
            rstSync <= {rstSync[0], 1'b1};
    end
    assign rstN = rstSync[1];

    // Input synchronisers; bit 2 is an extra stage for edge detection
    logic [2:0] syncQ [SW];
    logic [SW-1:0] pinsRaw;
    logic [SW-1:0] pinS;
    logic [SW-1:0] pinPrev;
    assign pinsRaw = {host_or_strap_sel, incircuit_test_n,
                      mute_on_loss_enable, monitor_tip_in, monitor_ring_in,
                      tx_all_ones_sel, local_loopback_in,
                      remote_loopback_in, signal_loss_threshold_sel,
                      e3_mode_in, tx_clock_in, reference_clock_in,
                      rx_recovered_clock_in};
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            for (int i = 0; i < SW; i++)
                syncQ[i] <= 3'h0;
        end else begin
            for (int i = 0; i < SW; i++)
                syncQ[i] <= {syncQ[i][1:0], pinsRaw[i]};
        end
    end
    for (genvar g = 0; g < SW; g++) begin : gUnpack
        assign pinS[g] = syncQ[g][1];
        assign pinPrev[g] = syncQ[g][2];
    end

    wire logic           hostMode = pinS[SW-1];
    wire logic           ictN     = pinS[SW-2];
    wire logic           muteS    = pinS[SW-3];
    wire logic [NCH-1:0] aosS     = pinS[7*NCH +: NCH];
    wire logic [NCH-1:0] llbS     = pinS[6*NCH +: NCH];
    wire logic [NCH-1:0] rlbS     = pinS[5*NCH +: NCH];
    wire logic [NCH-1:0] e3S      = pinS[3*NCH +: NCH];
    logic [NCH-1:0] tipEdge, ringEdge, txTick, refTick, rxTick;
    for (genvar c = 0; c < NCH; c++) begin : gEdge
        assign tipEdge[c]  = riseOf(syncQ[9*NCH + c]);
        assign ringEdge[c] = riseOf(syncQ[8*NCH + c]);
        assign txTick[c]   = riseOf(syncQ[2*NCH + c]);
        assign refTick[c]  = riseOf(syncQ[NCH + c]);
        assign rxTick[c]   = riseOf(syncQ[c]);
    end

    // Threshold strap caught once, after the synchroniser has filled
    logic [NCH-1:0] thrSelQ;
    logic [1:0]     thrWaitQ;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            thrSelQ <= '0;
            thrWaitQ <= 2'h0;
        end else if (thrWaitQ != 2'h3) begin
            thrWaitQ <= thrWaitQ + 2'h1;
            if (thrWaitQ == 2'h2)
                thrSelQ <= pinS[4*NCH +: NCH];
        end
    end

    // Register bus: zero wait on write, one wait on read
    logic [31:0] ctrlQ;
    logic        rdDoneQ;
    logic [31:0] rdDataQ;
    logic [SW-1:0] unusedPrev;
    wire logic selCtrl = avs_address == lca_pkg::REG_CTRL;
    wire logic selStat = avs_address == lca_pkg::REG_STATUS;
    wire logic selLos  = avs_address == lca_pkg::REG_LOS;
    logic [31:0] statusWord;
    logic [31:0] rdMux;
    assign unusedPrev = pinPrev;
    assign rdMux = selCtrl ? ctrlQ : selStat ? statusWord
                 : selLos ? {28'h0, 4'(thrSelQ)} : 32'h0;
    assign avs_waitrequest = avs_read & ~rdDoneQ;
    assign avs_readdata = rdDataQ;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ctrlQ <= lca_pkg::CTRL_RESET;
            rdDoneQ <= 1'b0;
            rdDataQ <= 32'h0;
        end else begin
            if (avs_write && selCtrl)
                ctrlQ <= avs_writedata;
            rdDoneQ <= avs_read & ~rdDoneQ;
            if (avs_read && !rdDoneQ)
                rdDataQ <= rdMux;
        end
    end

    // Effective per-channel configuration
    lca_pkg::lca_chan_cfg_s cfg [NCH];
    logic [NCH-1:0] e3Eff;
    for (genvar c = 0; c < NCH; c++) begin : gCfg
        assign cfg[c] = hostMode ?
            {ctrlQ[lca_pkg::CTRL_AOS_POS + c],
             ctrlQ[lca_pkg::CTRL_LLB_POS + c],
             ctrlQ[lca_pkg::CTRL_RLB_POS + c],
             ctrlQ[lca_pkg::CTRL_MUTE_POS + c]}
            : {aosS[c], llbS[c], rlbS[c], muteS};
        assign e3Eff[c] = hostMode ? ctrlQ[lca_pkg::CTRL_E3_POS + c]
                                   : e3S[c];
        always_comb begin
            case ({cfg[c].localLb, cfg[c].remoteLb})
                2'b10:   loopbackMode[c] = lca_pkg::LB_ANALOG_LOCAL;
                2'b11:   loopbackMode[c] = lca_pkg::LB_DIGITAL_LOCAL;
                2'b01:   loopbackMode[c] = lca_pkg::LB_REMOTE;
                default: loopbackMode[c] = lca_pkg::LB_NONE;
            endcase
        end
    end

    // Per-channel alarms and datapath
    logic [FW-1:0] idleCntQ [NCH];
    logic [LW-1:0] refCntQ [NCH];
    logic [CW-1:0] rxCntQ [NCH];
    logic [NCH-1:0] dmoQ, lolQ, losQ, lcvQ, rpQ, rnQ, ttQ, trQ, markQ;
    logic [NCH-1:0] losNow;
    for (genvar c = 0; c < NCH; c++) begin : gChan
        // Threshold only matters outside E3
        assign losNow[c] = (!e3Eff[c] && thrSelQ[c]) ?
                           rx_loss_hi_thr_in[c] : rx_loss_lo_thr_in[c];
        always_ff @(posedge clk or negedge rstN) begin
            if (!rstN) begin
                idleCntQ[c] <= '0;
                dmoQ[c] <= 1'b0;
                refCntQ[c] <= '0;
                rxCntQ[c] <= '0;
                lolQ[c] <= 1'b0;
                markQ[c] <= 1'b0;
                ttQ[c] <= 1'b0;
                trQ[c] <= 1'b0;
            end else begin
                if (tipEdge[c] || ringEdge[c]) begin
                    idleCntQ[c] <= '0;
                    dmoQ[c] <= 1'b0;
                end else if (txTick[c]) begin
                    if (idleCntQ[c] >= FAULT_CNT - 8'h1)
                        dmoQ[c] <= 1'b1;
                    else
                        idleCntQ[c] <= idleCntQ[c] + 8'h1;
                end
                if (refTick[c] && refCntQ[c] == WIN_END - 1'b1) begin
                    refCntQ[c] <= '0;
                    rxCntQ[c] <= '0;
                    lolQ[c] <= rxCntQ[c] < CNT_LO ||
                               rxCntQ[c] > CNT_HI;
                end else begin
                    if (refTick[c])
                        refCntQ[c] <= refCntQ[c] + 1'b1;
                    if (rxTick[c] && rxCntQ[c] != '1)
                        rxCntQ[c] <= rxCntQ[c] + 1'b1;
                end
                if (txTick[c]) begin
                    if (cfg[c].allOnes) begin
                        markQ[c] <= ~markQ[c];
                        ttQ[c] <= ~markQ[c];
                        trQ[c] <= markQ[c];
                    end else begin
                        ttQ[c] <= tx_data_pos_in[c];
                        trQ[c] <= tx_data_neg_in[c];
                    end
                end
            end
        end
        always_ff @(posedge clk or negedge rstN) begin
            if (!rstN) begin
                losQ[c] <= 1'b0;
                lcvQ[c] <= 1'b0;
                rpQ[c] <= 1'b0;
                rnQ[c] <= 1'b0;
            end else begin
                losQ[c] <= losNow[c];
                lcvQ[c] <= rx_code_viol_in[c];
                rpQ[c] <= rx_dec_pos_in[c] &
                          ~(cfg[c].muteEn & losNow[c]);
                rnQ[c] <= rx_dec_neg_in[c] &
                          ~(cfg[c].muteEn & losNow[c]);
            end
        end
    end

    assign statusWord = {19'h0, hostMode, 4'(lolQ), 4'(losQ), 4'(dmoQ)};
    assign outputsEnable      = ictN;
    assign drive_fault_out    = dmoQ;
    assign rx_signal_loss_out = losQ;
    assign rx_lock_loss_out   = lolQ;
    assign code_violation_out = lcvQ;
    assign rx_data_pos        = rpQ;
    assign rx_data_neg        = rnQ;
    assign tx_line_tip        = ttQ;
    assign tx_line_ring       = trQ;

    // Fault may rise only after a full idle window of tx ticks
    a_fault_needs_idle: assert property (@(posedge clk)
        disable iff (!rstN)
        $rose(dmoQ[0]) |-> $past(idleCntQ[0]) == FAULT_CNT - 8'h1)
        else $error("drive fault rose early");
    a_fault_clears_pulse: assert property (@(posedge clk)
        disable iff (!rstN)
        $fell(dmoQ[0]) |-> $past(tipEdge[0] | ringEdge[0]))
        else $error("drive fault cleared without pulse");
    a_all_ones_marks: assert property (@(posedge clk)
        disable iff (!rstN)
        txTick[0] && cfg[0].allOnes |=> ttQ[0] != trQ[0])
        else $error("all ones lost a mark");
    a_host_ignores_pin: assert property (@(posedge clk)
        disable iff (!rstN)
        hostMode |-> cfg[0].allOnes == ctrlQ[lca_pkg::CTRL_AOS_POS])
        else $error("host mode used pin");
    a_mute_forces_low: assert property (@(posedge clk)
        disable iff (!rstN)
        cfg[0].muteEn && losNow[0] |=> !rpQ[0] && !rnQ[0])
        else $error("data not muted");
    a_mute_off_passes: assert property (@(posedge clk)
        disable iff (!rstN)
        !cfg[0].muteEn |=> rpQ[0] == $past(rx_dec_pos_in[0]))
        else $error("data muted wrongly");
    a_viol_follows: assert property (@(posedge clk)
        disable iff (!rstN)
        ##1 lcvQ[0] == $past(rx_code_viol_in[0]))
        else $error("violation pulse lost");
    a_digital_loop: assert property (@(posedge clk)
        disable iff (!rstN)
        cfg[0].localLb && cfg[0].remoteLb
        |-> loopbackMode[0] == lca_pkg::LB_DIGITAL_LOCAL)
        else $error("loopback decode wrong");
    a_analog_loop: assert property (@(posedge clk)
        disable iff (!rstN)
        cfg[0].localLb && !cfg[0].remoteLb
        |-> loopbackMode[0] == lca_pkg::LB_ANALOG_LOCAL)
        else $error("analog loopback decode wrong");
    a_remote_loop: assert property (@(posedge clk)
        disable iff (!rstN)
        !cfg[0].localLb && cfg[0].remoteLb
        |-> loopbackMode[0] == lca_pkg::LB_REMOTE)
        else $error("remote loopback decode wrong");
    a_host_mute_reg: assert property (@(posedge clk)
        disable iff (!rstN)
        hostMode |-> cfg[0].muteEn == ctrlQ[lca_pkg::CTRL_MUTE_POS])
        else $error("host mode used mute pin");
    a_los_high_thr: assert property (@(posedge clk)
        disable iff (!rstN)
        !e3Eff[0] && thrSelQ[0]
        |=> losQ[0] == $past(rx_loss_hi_thr_in[0]))
        else $error("high threshold not used");
    a_los_e3_low_thr: assert property (@(posedge clk)
        disable iff (!rstN)
        e3Eff[NCH-1]
        |=> losQ[NCH-1] == $past(rx_loss_lo_thr_in[NCH-1]))
        else $error("threshold used in E3");
    a_lock_at_window: assert property (@(posedge clk)
        disable iff (!rstN)
        $changed(lolQ[0]) |-> $past(refTick[0]))
        else $error("lock flag moved mid window");
    a_ict_floats: assert property (@(posedge clk)
        disable iff (!rstN)
        !ictN |-> !outputsEnable)
        else $error("outputs driven in test");
    c_fault_set: cover property (@(posedge clk) $rose(dmoQ[0]));
    c_lock_lost: cover property (@(posedge clk) $rose(lolQ[0]));
    c_muted: cover property (@(posedge clk) cfg[0].muteEn && losNow[0]);
    c_bus_read: cover property (@(posedge clk) avs_read && rdDoneQ);
endmodule

// ==== sim/lca_line_partner.sv ====
// Far-side model: line clocks, monitor taps and threshold straps.
// Assumes the bench clock; every line clock is divided from it.
module lca_line_partner #(
    parameter logic [2:0] THR_STRAP = 3'h5
) (
    input  wire logic       clk,
    input  wire logic [2:0] monOn,
    input  wire logic       rxFast,
    output logic      [2:0] txClk,
    output logic      [2:0] refClk,
    output logic      [2:0] rxClk,
    output logic      [2:0] monTip,
    output logic      [2:0] monRing,
    output logic      [2:0] thrStrap
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] txCnt  = 4'h0;
    logic [3:0] refCnt = 4'h0;
    logic [3:0] rxCnt  = 4'h0;
    assign thrStrap = THR_STRAP;
    // Idle taps rest at the pull-up level
    assign monTip  = (monOn & txClk) | ~monOn;
    assign monRing = 3'h7;
    assign txClk   = {3{txCnt < 4'h4}};
    assign refClk  = {3{refCnt < 4'h5}};
    assign rxClk   = {3{rxCnt < 4'h5}};
    always @(posedge clk) begin
        txCnt  <= (txCnt == 4'h7) ? 4'h0 : txCnt + 4'h1;
        refCnt <= (refCnt == 4'h9) ? 4'h0 : refCnt + 4'h1;
        rxCnt  <= (rxCnt >= (rxFast ? 4'h8 : 4'h9)) ? 4'h0 : rxCnt + 4'h1;
    end
endmodule

// ==== sim/lca_control_alarm_tb.sv ====
// Self-checking bench for the line-unit control and alarm block.
// Assumes lca_pkg, the design and the line partner are compiled first.
module lca_control_alarm_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  avsAddress = 4'h0;
    logic        avsRead = 1'b0;
    logic        avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [31:0] avsReaddata;
    logic        avsWaitrequest;
    logic        hostSel = 1'b0;
    logic        ictN = 1'b1;
    logic        muteEn = 1'b0;
    logic        rxFast = 1'b0;
    logic [2:0]  allOnes = 3'h0, llb = 3'h0, rlb = 3'h0, e3 = 3'h4;
    logic [2:0]  txPos = 3'h0, txNeg = 3'h0, decPos = 3'h7, decNeg = 3'h7;
    logic [2:0]  viol = 3'h0, hiThr = 3'h0, loThr = 3'h0, monOn = 3'h7;
    logic [2:0]  txClk, refClk, rxClk, monTip, monRing, thrStrap;
    logic [2:0]  fault, los, lol, cv, rPos, rNeg, tip, ring;
    logic        outEn;
    lca_pkg::lca_loopback_e [2:0] lbMode;
    int          errTotal = 0;
    int          testsRun = 0;

    lca_line_partner partner (.clk(clk), .monOn(monOn), .rxFast(rxFast),
        .txClk(txClk), .refClk(refClk), .rxClk(rxClk), .monTip(monTip),
        .monRing(monRing), .thrStrap(thrStrap));
    lca_control_alarm uut (.clk(clk), .rst_n(rst_n),
        .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
        .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
        .avs_waitrequest(avsWaitrequest), .host_or_strap_sel(hostSel),
        .incircuit_test_n(ictN), .mute_on_loss_enable(muteEn),
        .monitor_tip_in(monTip), .monitor_ring_in(monRing),
        .tx_all_ones_sel(allOnes), .local_loopback_in(llb),
        .remote_loopback_in(rlb), .signal_loss_threshold_sel(thrStrap),
        .e3_mode_in(e3), .tx_clock_in(txClk), .reference_clock_in(refClk),
        .rx_recovered_clock_in(rxClk), .tx_data_pos_in(txPos),
        .tx_data_neg_in(txNeg), .rx_dec_pos_in(decPos),
        .rx_dec_neg_in(decNeg), .rx_code_viol_in(viol),
        .rx_loss_hi_thr_in(hiThr), .rx_loss_lo_thr_in(loThr),
        .drive_fault_out(fault), .rx_signal_loss_out(los),
        .rx_lock_loss_out(lol), .code_violation_out(cv), .rx_data_pos(rPos),
        .rx_data_neg(rNeg), .tx_line_tip(tip), .tx_line_ring(ring),
        .loopbackMode(lbMode), .outputsEnable(outEn));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        testsRun++;
        if (got !== exp) begin
            errTotal++;
            $display("MISMATCH %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic results();
        if (errTotal == 0 && testsRun > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Settle n edges, then sample at the falling edge
    task automatic at(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic xfer(input logic wr, input logic [3:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avsAddress   <= a;
        avsWritedata <= d;
        avsWrite     <= wr;
        avsRead      <= ~wr;
        do @(posedge clk); while (avsWaitrequest !== 1'b0);
        q = avsReaddata;
        avsWrite <= 1'b0;
        avsRead  <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] m,
                      input logic [31:0] e, input string what);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(q & m, e, what);
    endtask

    task automatic tRegs();
        rd(lca_pkg::REG_CTRL, 32'hFFFF_FFFF, lca_pkg::CTRL_RESET, "ctrl rst");
        wr(lca_pkg::REG_CTRL, 32'h0000_0650);
        wr(lca_pkg::REG_STATUS, 32'hFFFF_FFFF);
        rd(lca_pkg::REG_CTRL, 32'hFFFF_FFFF, 32'h0000_0650, "ctrl back");
        rd(4'hC, 32'hFFFF_FFFF, 32'h0, "unmapped read");
        rd(lca_pkg::REG_LOS, 32'hFFFF_FFFF, 32'h5, "strap caught");
        rd(lca_pkg::REG_STATUS, 32'h0000_1000, 32'h0, "hw flag");
    endtask

    task automatic tIct();
        @(posedge clk);
        ictN <= 1'b0;
        at(8);
        chk(32'(outEn), 32'h0, "outputs float");
        @(posedge clk);
        ictN <= 1'b1;
        at(8);
        chk(32'(outEn), 32'h1, "outputs driven");
    endtask

    task automatic tLoop();
        lca_pkg::lca_loopback_e em [4] = '{lca_pkg::LB_NONE,
            lca_pkg::LB_ANALOG_LOCAL, lca_pkg::LB_REMOTE,
            lca_pkg::LB_DIGITAL_LOCAL};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            llb <= {3{i[0]}};
            rlb <= {3{i[1]}};
            at(6);
            chk(32'(lbMode), 32'({3{em[i]}}), "hw loop");
        end
        @(posedge clk);
        hostSel <= 1'b1;
        at(6);
        chk(32'(lbMode), 32'({lca_pkg::LB_DIGITAL_LOCAL, lca_pkg::LB_REMOTE,
            lca_pkg::LB_ANALOG_LOCAL}), "host loop");
        rd(lca_pkg::REG_STATUS, 32'h1000, 32'h1000, "host flag");
        @(posedge clk);
        hostSel <= 1'b0;
        llb <= 3'h0;
        rlb <= 3'h0;
        wr(lca_pkg::REG_CTRL, 32'h0);
    endtask

    // Marks alternate tip and ring on each transmit clock rise
    task automatic chkAlt(input int ch, input logic alt, input string what);
        logic p;
        @(posedge txClk[ch]);
        at(5);
        p = tip[ch];
        for (int k = 0; k < 4; k++) begin
            @(posedge txClk[ch]);
            at(5);
            chk(32'({tip[ch], ring[ch]}),
                alt ? 32'({~p, p}) : 32'({txPos[ch], txNeg[ch]}), what);
            p = tip[ch];
        end
    endtask

    task automatic tAllOnes();
        @(posedge clk);
        allOnes <= 3'h2;
        txPos <= 3'h3;
        chkAlt(1, 1'b1, "hw all ones");
        chkAlt(0, 1'b0, "ch0 data");
        @(posedge clk);
        hostSel <= 1'b1;
        wr(lca_pkg::REG_CTRL, 32'h0000_0001);
        chkAlt(0, 1'b1, "host all ones");
        chkAlt(1, 1'b0, "pin ignored");
        @(posedge clk);
        hostSel <= 1'b0;
        allOnes <= 3'h0;
        txPos <= 3'h0;
        wr(lca_pkg::REG_CTRL, 32'h0);
    endtask

    task automatic tLos();
        @(posedge clk);
        hiThr <= 3'h7;
        muteEn <= 1'b1;
        at(6);
        chk(32'(los), 32'h1, "los high thr");
        chk(32'({rPos, rNeg}), 32'h36, "muted");
        @(posedge clk);
        muteEn <= 1'b0;
        hiThr <= 3'h0;
        loThr <= 3'h7;
        at(6);
        chk(32'(los), 32'h6, "los low thr");
        chk(32'({rPos, rNeg}), 32'h3F, "unmuted");
        @(posedge clk);
        hostSel <= 1'b1;
        muteEn <= 1'b1;
        hiThr <= 3'h7;
        loThr <= 3'h0;
        at(6);
        chk(32'(los), 32'h5, "host los");
        chk(32'(rPos), 32'h7, "mute pin off");
        wr(lca_pkg::REG_CTRL, 32'h0000_1000);
        at(6);
        chk(32'(rPos), 32'h6, "host mute");
        @(posedge clk);
        hostSel <= 1'b0;
        muteEn <= 1'b0;
        hiThr <= 3'h0;
        wr(lca_pkg::REG_CTRL, 32'h0);
    endtask

    task automatic tViol();
        @(posedge clk);
        viol <= 3'h5;
        @(posedge clk);
        viol <= 3'h0;
        @(negedge clk);
        chk(32'(cv), 32'h5, "viol pulse");
        @(negedge clk);
        chk(32'(cv), 32'h0, "viol low");
    endtask

    task automatic tFault();
        int n = 0;
        @(posedge clk);
        monOn <= 3'h6;
        while (fault[0] !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n >= 760 && n <= 1300), 32'h1, "fault delay");
        at(200);
        chk(32'(fault), 32'h1, "fault held");
        @(posedge clk);
        monOn <= 3'h7;
        at(20);
        chk(32'(fault), 32'h0, "fault cleared");
    endtask

    task automatic tLol();
        at(25000);
        chk(32'(lol), 32'h0, "locked");
        @(posedge clk);
        rxFast <= 1'b1;
        at(25000);
        chk(32'(lol), 32'h7, "lock lost");
    endtask

    initial begin
        #900000;
        errTotal++;
        $display("MISMATCH %0t: watchdog expired", $time);
        results();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        at(8);
        tRegs();
        tIct();
        tLoop();
        tAllOnes();
        tLos();
        tViol();
        tFault();
        tLol();
        results();
    end
endmodule
